// *** core/aspm_regs.vh ***
// Constants for the asynchronous serial port engine: modes, timing slices and frame lengths.
`ifndef ASPM_REGS_VH
`define ASPM_REGS_VH

// Mode codes formed as {mode_select_high, mode_select_low}.
`define ASPM_MODE_SYNC      2'h0
`define ASPM_MODE_TIMER10   2'h1
`define ASPM_MODE_OSC11     2'h2
`define ASPM_MODE_TIMER11   2'h3

// Sixteen-slice bit timing.
`define ASPM_SLICE_ZERO     4'h0
`define ASPM_SLICE_LAST     4'hF
`define ASPM_SAMPLE_FIRST   4'h7
`define ASPM_SAMPLE_SECOND  4'h8
`define ASPM_SAMPLE_THIRD   4'h9

// Oscillator prescale to the 16x tick: 2 clocks (/32) or 4 clocks (/64).
`define ASPM_OSC_LAST_FAST  2'h1
`define ASPM_OSC_LAST_SLOW  2'h3

// Frame lengths in bits and index of the receive stop bit.
`define ASPM_FRAME_10       4'hA
`define ASPM_FRAME_11       4'hB
`define ASPM_STOP_IDX_10    4'h9
`define ASPM_STOP_IDX_11    4'hA

// Synchronous mode shift clock phases for /4 and /12 periods.
`define ASPM_M0_FALL_FAST   4'h1
`define ASPM_M0_RISE_FAST   4'h3
`define ASPM_M0_LAST_FAST   4'h3
`define ASPM_M0_FALL_SLOW   4'h3
`define ASPM_M0_RISE_SLOW   4'h9
`define ASPM_M0_LAST_SLOW   4'hB
`define ASPM_M0_BIT_LAST    3'h7

`endif

// *** core/aspm_core.v ***
// Serial port engine: asynchronous modes 1 to 3 and the synchronous mode 0 shifter.
`include "aspm_regs.vh"

module aspm_core (
	// Clock and reset.
	input  wire       clock,
	input  wire       rst_b,
	// Serial buffer access from the processor.
	input  wire       serial_buffer_wr,
	input  wire [7:0] serial_buffer_wdata,
	output reg  [7:0] serial_buffer,
	// Serial control bits.
	input  wire       mode_select_low,
	input  wire       mode_select_high,
	input  wire       multiproc_select_bit,
	input  wire       rx_enable,
	input  wire       tx_ninth_bit_ctrl,
	input  wire       tx_done_clr,
	input  wire       rx_done_clr,
	output reg        tx_done_flag,
	output reg        rx_done_flag,
	output reg        rx_ninth_bit_flag,
	// Power control and timer.
	input  wire       rate_double_bit,
	input  wire       timer1_overflow,
	// Serial pins; the receive pin is two-way in mode 0.
	input  wire       rxd_in,
	output wire       rxd_out,
	output wire       rxd_oe,
	output wire       txd_pin
);

	// Decoded mode and mode classes.
	wire [1:0] mode        = {mode_select_high, mode_select_low};
	wire       mode_sync   = (mode == `ASPM_MODE_SYNC);
	wire       mode_ten    = (mode == `ASPM_MODE_TIMER10);
	wire       mode_timer  = (mode == `ASPM_MODE_TIMER10) || (mode == `ASPM_MODE_TIMER11);

	// Receive pin synchroniser; only the second stage feeds logic.
	reg        rxd_meta;
	reg        rxd_sync;

	// Rate generation state.
	reg  [1:0] osc_cnt;     // Oscillator prescaler count.
	reg        tmr_half;    // Alternating phase of timer overflows.
	wire [1:0] osc_last;    // Last prescaler count for the chosen rate.
	wire       tick16;      // One-cycle pulse at sixteen times the bit rate.

	// Transmit state.
	reg  [3:0] tx_slice;    // Free running divide-by-16 counter.
	reg        tx_pend;     // Frame loaded and not yet fully sent.
	reg [10:0] tx_shift;    // Outgoing bits, next bit in bit 0.
	reg  [3:0] tx_left;     // Bits still to drive.
	reg        tx_line;     // Asynchronous transmit level.
	wire       tx_roll;     // Rollover of the divide-by-16 counter.
	reg        tx_finish;   // Stop bit driven this cycle.

	// Receive state.
	reg        rx_busy;     // Frame in progress.
	reg        rx_last;     // Pin level at the previous 16x tick.
	reg  [3:0] rx_slice;    // Receive divide-by-16 counter.
	reg  [3:0] rx_bit;      // Index of the bit being sampled.
	reg        rx_s0;       // Sample at the 8th slice.
	reg        rx_s1;       // Sample at the 9th slice.
	reg  [8:0] rx_shift;    // Data bits and ninth bit, shifted in from the top.
	reg        rx_accept;   // Frame accepted this cycle.
	wire       rx_vote;     // Majority of the three samples.
	wire [3:0] rx_stop_idx; // Index of the stop bit for this mode.

	// Synchronous mode state.
	reg        m0_active;   // Shifter running.
	reg        m0_rx;       // Shifter is receiving rather than sending.
	reg  [3:0] m0_phase;    // Clock count within one bit.
	reg  [2:0] m0_bits;     // Bits completed.
	reg  [7:0] m0_shift;    // Shift register, bit 0 on the pin.
	reg        m0_tx_done;  // Eighth bit sent this cycle.
	reg        m0_rx_done;  // Eighth bit received this cycle.
	wire [3:0] m0_fall;     // Phase at which the shift clock falls.
	wire [3:0] m0_rise;     // Phase at which the shift clock rises.
	wire [3:0] m0_last;     // Last phase of the bit.
	wire       m0_clk;      // Shift clock level.

	// Two flip-flops bring the receive pin into the clock domain.
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rxd_meta <= 1'b1;
			rxd_sync <= 1'b1;
		end else begin
			rxd_meta <= rxd_in;
			rxd_sync <= rxd_meta;
		end
	end

	// The oscillator prescaler gives a 16x tick every 2 or 4 clocks.
	assign osc_last = rate_double_bit ? `ASPM_OSC_LAST_FAST : `ASPM_OSC_LAST_SLOW;

	// Prescaler and timer overflow halving run continuously.
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			osc_cnt  <= 2'h0;
			tmr_half <= 1'b0;
		end else begin
			if (osc_cnt >= osc_last) begin
				osc_cnt <= 2'h0;
			end else begin
				osc_cnt <= osc_cnt + 2'h1;
			end
			if (timer1_overflow) begin
				tmr_half <= ~tmr_half;
			end
		end
	end

	// Timer modes use every overflow when doubled, else every second one.
	assign tick16 = mode_timer ? (timer1_overflow & (rate_double_bit | tmr_half))
	                           : ((mode == `ASPM_MODE_OSC11) & (osc_cnt == osc_last));

	// The transmit slice counter runs freely so frames align to its rollover.
	assign tx_roll = tick16 & (tx_slice == `ASPM_SLICE_LAST);

	// Asynchronous transmitter: a write loads the frame, rollovers drive each bit.
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tx_slice  <= `ASPM_SLICE_ZERO;
			tx_pend   <= 1'b0;
			tx_shift  <= 11'h7FF;
			tx_left   <= 4'h0;
			tx_line   <= 1'b1;
			tx_finish <= 1'b0;
		end else begin
			tx_finish <= 1'b0;
			if (tick16) begin
				tx_slice <= tx_slice + 4'h1;
			end
			if (serial_buffer_wr && !mode_sync) begin
				// Start, data LSB first, then ninth bit or stop, idle level above.
				tx_pend <= 1'b1;
				if (mode_ten) begin
					tx_shift <= {2'h3, serial_buffer_wdata, 1'b0};
					tx_left  <= `ASPM_FRAME_10;
				end else begin
					tx_shift <= {1'b1, tx_ninth_bit_ctrl, serial_buffer_wdata, 1'b0};
					tx_left  <= `ASPM_FRAME_11;
				end
			end else if (tx_pend && tx_roll) begin
				// Each rollover puts the next bit on the pin.
				tx_line  <= tx_shift[0];
				tx_shift <= {1'b1, tx_shift[10:1]};
				tx_left  <= tx_left - 4'h1;
				if (tx_left == 4'h1) begin
					// The stop bit goes out now, so the frame is done.
					tx_pend   <= 1'b0;
					tx_finish <= 1'b1;
				end
			end
		end
	end

	// Majority of the two stored samples and the live third sample.
	assign rx_vote     = (rx_s0 & rx_s1) | (rx_s0 & rxd_sync) | (rx_s1 & rxd_sync);
	assign rx_stop_idx = mode_ten ? `ASPM_STOP_IDX_10 : `ASPM_STOP_IDX_11;

	// Asynchronous receiver: edge hunt, slice count, voting and frame acceptance.
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rx_busy           <= 1'b0;
			rx_last           <= 1'b1;
			rx_slice          <= `ASPM_SLICE_ZERO;
			rx_bit            <= 4'h0;
			rx_s0             <= 1'b1;
			rx_s1             <= 1'b1;
			rx_shift          <= 9'h000;
			rx_accept         <= 1'b0;
			rx_ninth_bit_flag <= 1'b0;
		end else begin
			rx_accept <= 1'b0;
			if (tick16) begin
				rx_last <= rxd_sync;
			end
			if (!rx_busy) begin
				// Watch for a high-to-low step between 16x ticks.
				if (tick16 && rx_enable && !mode_sync && rx_last && !rxd_sync) begin
					rx_busy  <= 1'b1;
					rx_slice <= `ASPM_SLICE_ZERO;
					rx_bit   <= 4'h0;
				end
			end else if (mode_sync) begin
				// A switch to synchronous mode drops the frame.
				rx_busy <= 1'b0;
			end else if (tick16) begin
				rx_slice <= rx_slice + 4'h1;
				if (rx_slice == `ASPM_SAMPLE_FIRST) begin
					rx_s0 <= rxd_sync;
				end
				if (rx_slice == `ASPM_SAMPLE_SECOND) begin
					rx_s1 <= rxd_sync;
				end
				if (rx_slice == `ASPM_SAMPLE_THIRD) begin
					if (rx_bit == 4'h0 && rx_vote) begin
						// A high start bit was only noise.
						rx_busy <= 1'b0;
					end else if (rx_bit == rx_stop_idx) begin
						// Mid stop bit: decide acceptance and resume hunting.
						rx_busy <= 1'b0;
						if (!rx_done_flag && (!multiproc_select_bit || rx_vote)) begin
							rx_accept <= 1'b1;
							if (mode_ten) begin
								rx_ninth_bit_flag <= rx_vote;
							end else begin
								rx_ninth_bit_flag <= rx_shift[8];
							end
						end
					end else begin
						if (rx_bit != 4'h0) begin
							rx_shift <= {rx_vote, rx_shift[8:1]};
						end
						rx_bit <= rx_bit + 4'h1;
					end
				end
			end
		end
	end

	// Synchronous shift clock phases follow the multiprocessor bit.
	assign m0_fall = multiproc_select_bit ? `ASPM_M0_FALL_FAST : `ASPM_M0_FALL_SLOW;
	assign m0_rise = multiproc_select_bit ? `ASPM_M0_RISE_FAST : `ASPM_M0_RISE_SLOW;
	assign m0_last = multiproc_select_bit ? `ASPM_M0_LAST_FAST : `ASPM_M0_LAST_SLOW;
	assign m0_clk  = !(m0_active && (m0_phase >= m0_fall) && (m0_phase < m0_rise));

	// Synchronous shifter: a write sends eight bits, else enabled reception runs.
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			m0_active  <= 1'b0;
			m0_rx      <= 1'b0;
			m0_phase   <= 4'h0;
			m0_bits    <= 3'h0;
			m0_shift   <= 8'hFF;
			m0_tx_done <= 1'b0;
			m0_rx_done <= 1'b0;
		end else begin
			m0_tx_done <= 1'b0;
			m0_rx_done <= 1'b0;
			if (!mode_sync) begin
				m0_active <= 1'b0;
			end else if (!m0_active) begin
				m0_phase <= 4'h0;
				m0_bits  <= 3'h0;
				if (serial_buffer_wr) begin
					m0_active <= 1'b1;
					m0_rx     <= 1'b0;
					m0_shift  <= serial_buffer_wdata;
				end else if (rx_enable && !rx_done_flag && !m0_rx_done) begin
					// The done pulse still stands for the flag about to rise, so no restart.
					m0_active <= 1'b1;
					m0_rx     <= 1'b1;
				end
			end else begin
				// Receive latches the pin as the shift clock rises.
				if (m0_rx && m0_phase == m0_rise) begin
					m0_shift <= {rxd_sync, m0_shift[7:1]};
				end
				if (m0_phase >= m0_last) begin
					m0_phase <= 4'h0;
					m0_bits  <= m0_bits + 3'h1;
					if (!m0_rx) begin
						m0_shift <= {1'b1, m0_shift[7:1]};
					end
					if (m0_bits == `ASPM_M0_BIT_LAST) begin
						m0_active  <= 1'b0;
						m0_tx_done <= !m0_rx;
						m0_rx_done <= m0_rx;
					end
				end else begin
					m0_phase <= m0_phase + 4'h1;
				end
			end
		end
	end

	// Flags: a hardware set in the same cycle as a clear wins.
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tx_done_flag  <= 1'b0;
			rx_done_flag  <= 1'b0;
			serial_buffer <= 8'h00;
		end else begin
			tx_done_flag <= tx_finish | m0_tx_done | (tx_done_flag & ~tx_done_clr);
			rx_done_flag <= rx_accept | m0_rx_done | (rx_done_flag & ~rx_done_clr);
			if (m0_rx_done) begin
				serial_buffer <= m0_shift;
			end else if (rx_accept) begin
				// Reads see only this receive register, never the transmit data.
				serial_buffer <= mode_ten ? rx_shift[8:1] : rx_shift[7:0];
			end
		end
	end

	// Pins: mode 0 drives data on the receive pin and the shift clock on transmit.
	assign rxd_out = m0_shift[0];
	assign rxd_oe  = mode_sync & m0_active & ~m0_rx;
	assign txd_pin = mode_sync ? m0_clk : tx_line;

endmodule // aspm_core

// *** dv/aspm_assertions.sv ***
// Checker for the serial port engine: flag, buffer and pin relations at the ports.
module aspm_checker (
	// Clock and reset.
	input wire logic       clock,
	input wire logic       rst_b,
	// Processor side.
	input wire logic       serial_buffer_wr,
	input wire logic       mode_select_low,
	input wire logic       mode_select_high,
	input wire logic       rx_enable,
	input wire logic       tx_done_clr,
	input wire logic       rx_done_clr,
	input wire logic       tx_done_flag,
	input wire logic       rx_done_flag,
	input wire logic       rx_ninth_bit_flag,
	input wire logic [7:0] serial_buffer,
	// Pins.
	input wire logic       rxd_oe,
	input wire logic       txd_pin
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	wire        async_mode = mode_select_low | mode_select_high; // Modes 1 to 3.
	logic       wr_seen;  // A buffer write happened since reset.
	logic [8:0] since_wr; // Cycles since the last write, saturating.
	// Tracks the last buffer write so flag rises can be tied to it.
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wr_seen <= 1'b0;
			since_wr <= 9'h000;
		end else if (serial_buffer_wr) begin
			wr_seen <= 1'b1;
			since_wr <= 9'h000;
		end else if (since_wr != 9'h1FF) begin
			since_wr <= since_wr + 9'h001;
		end
	end
	tx_flag_sticky_a: assert property (tx_done_flag && !tx_done_clr |=> tx_done_flag)
		else $error("transmit flag dropped without a clear");
	rx_flag_sticky_a: assert property (rx_done_flag && !rx_done_clr |=> rx_done_flag)
		else $error("receive flag dropped without a clear");
	buffer_guard_a: assert property ($changed(serial_buffer) |-> !$past(rx_done_flag))
		else $error("receive buffer loaded while flag set");
	ninth_guard_a: assert property ($changed(rx_ninth_bit_flag) |-> !$past(rx_done_flag))
		else $error("ninth flag loaded while receive flag set");
	rx_enable_a: assert property ($rose(rx_done_flag) |-> $past(rx_enable))
		else $error("frame accepted while receive disabled");
	tx_cause_a: assert property ($rose(tx_done_flag) && async_mode |->
		wr_seen && since_wr >= 9'h091)
		else $error("transmit flag rose too soon after a write");
	stop_hold_a: assert property ($rose(tx_done_flag) && async_mode |-> txd_pin [*8])
		else $error("stop level missing as transmit flag rose");
	async_oe_a: assert property (async_mode |-> !rxd_oe)
		else $error("receive pin driven in an async mode");
	idle_high_a: assert property (async_mode && !wr_seen |-> txd_pin)
		else $error("transmit pin left idle level with no write");
	cover property ($rose(tx_done_flag));
	cover property ($rose(rx_done_flag));
	cover property ($changed(serial_buffer));
endmodule // aspm_checker

bind aspm_core aspm_checker u_chk (.clock, .rst_b, .serial_buffer_wr, .mode_select_low,
	.mode_select_high, .rx_enable, .tx_done_clr, .rx_done_clr, .tx_done_flag,
	.rx_done_flag, .rx_ninth_bit_flag, .serial_buffer, .rxd_oe, .txd_pin);

// *** dv/aspm_remote.sv ***
// Remote async device: sends frames to the receive pin and captures sent frames.
module aspm_remote (
	// Clock.
	input  wire logic clock,
	// Serial lines.
	input  wire logic txd_pin,
	output logic      rxd_line
);
	timeunit 1ns;
	timeprecision 100ps;
	int bit_clks = 32; // Clocks per bit, set by the bench.
	// An idle async line rests high.
	initial rxd_line = 1'b1;
	// Sends start, n bits LSB first and a stop level; a nonzero low_clks sends a short glitch.
	task automatic send(input logic [9:0] bits, input int n, input logic stp, input int low_clks);
		rxd_line <= 1'b0;
		repeat ((low_clks != 0) ? low_clks : bit_clks) @(posedge clock);
		if (low_clks == 0) begin
			for (int i = 0; i < n; i++) begin
				rxd_line <= bits[i];
				repeat (bit_clks) @(posedge clock);
			end
			rxd_line <= stp;
			repeat (bit_clks) @(posedge clock);
		end
		rxd_line <= 1'b1;
		repeat (bit_clks) @(posedge clock);
	endtask
	// Answers a synchronous receive: each bit goes out as the shift clock falls.
	task automatic feed_sync(input logic [7:0] bits);
		for (int i = 0; i < 8; i++) begin
			@(negedge txd_pin);
			rxd_line <= bits[i];
		end
		@(posedge txd_pin);
		rxd_line <= 1'b1;
	endtask
	// Captures n bits of a frame at mid-bit, start bit at index 0.
	task automatic catch(input int n, output logic [10:0] got);
		got = 11'h000;
		wait (txd_pin === 1'b0);
		repeat (bit_clks / 2) @(posedge clock);
		for (int i = 0; i < n; i++) begin
			got[i] = txd_pin;
			repeat (bit_clks) @(posedge clock);
		end
	endtask
endmodule // aspm_remote

// *** dv/aspm_core_tb.sv ***
// Self-checking bench for the serial port engine against a remote partner model.
module aspm_core_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clock = 1'b0;                          // 250 MHz clock.
	logic       rst_b = 1'b1;                          // Active-low reset.
	logic       serial_buffer_wr = 1'b0, tx_ninth_bit_ctrl = 1'b0; // Write strobe and ninth bit.
	logic [7:0] serial_buffer_wdata = 8'h00;                    // Byte to send.
	logic       mode_select_low = 1'b1, mode_select_high = 1'b0; // Mode 1 at start.
	logic       multiproc_select_bit = 1'b0, rx_enable = 1'b0;
	logic       tx_done_clr = 1'b0, rx_done_clr = 1'b0, rate_double_bit = 1'b1;
	logic       timer1_overflow = 1'b0;                // Overflow every second cycle.
	logic [7:0] exp_buf = 8'h00;                       // Expected receive buffer.
	logic       exp_nin = 1'b0;                        // Expected ninth flag.
	wire  [7:0] serial_buffer;
	wire        tx_done_flag, rx_done_flag, rx_ninth_bit_flag;
	wire        rxd_in, rxd_out, rxd_oe, txd_pin, rxd_line;
	int         errors = 0;
	int         n_compared = 0;
	// The receive pin carries our drive only while the engine does not drive it.
	assign rxd_in = rxd_oe ? rxd_out : rxd_line;
	aspm_core u_dut (.clock, .rst_b, .serial_buffer_wr, .serial_buffer_wdata, .serial_buffer, .mode_select_low,
		.mode_select_high, .multiproc_select_bit, .rx_enable, .tx_ninth_bit_ctrl,
		.tx_done_clr, .rx_done_clr, .tx_done_flag, .rx_done_flag, .rx_ninth_bit_flag,
		.rate_double_bit, .timer1_overflow, .rxd_in, .rxd_out, .rxd_oe, .txd_pin);
	aspm_remote u_rem (.clock, .txd_pin, .rxd_line);
	// Clock and a steady timer overflow stream.
	initial forever #2 clock = ~clock;
	always @(posedge clock) #1 timer1_overflow = ~timer1_overflow;
	// Compares one result and counts it.
	task automatic cmp(input string what, input logic [10:0] exp, input logic [10:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Selects mode and rate, clears the transmit flag and, when clr is set, the receive flag for one cycle.
	task automatic setup(input logic [1:0] md, input logic rd, input logic clr);
		#1 {mode_select_high, mode_select_low} = md;
		rate_double_bit = rd;
		u_rem.bit_clks = rd ? 32 : 64;
		tx_done_clr = 1'b1;
		rx_done_clr = clr;
		@(posedge clock);
		#1 tx_done_clr = 1'b0;
		rx_done_clr = 1'b0;
	endtask
	// Sends one byte and checks the frame on the pin and the done flag.
	task automatic t_tx(input logic [1:0] md, input logic rd, input logic [7:0] d, input logic nb);
		logic [10:0] got;
		setup(md, rd, 1'b1);
		serial_buffer_wdata = d;
		tx_ninth_bit_ctrl = nb;
		serial_buffer_wr = 1'b1;
		@(posedge clock);
		#1 serial_buffer_wr = 1'b0;
		u_rem.catch((md == 2'h1) ? 10 : 11, got);
		cmp("tx frame", (md == 2'h1) ? {2'h1, d, 1'b0} : {1'b1, nb, d, 1'b0}, got);
		cmp("tx done", 11'h001, 11'(tx_done_flag));
		$display("tx test mode %0d rate %0d ended", md, rd);
	endtask
	// Receives one frame and checks buffer, ninth flag and done flag.
	task automatic t_rx(input logic [1:0] md, input logic rd, input logic [8:0] d,
		input logic stp, input logic mp, input logic en, input logic clr, input logic take);
		setup(md, rd, clr);
		multiproc_select_bit = mp;
		rx_enable = en;
		u_rem.send({1'b0, d}, (md == 2'h1) ? 8 : 9, stp, 0);
		if (take) begin
			exp_buf = d[7:0];
			exp_nin = (md == 2'h1) ? stp : d[8];
		end
		cmp("rx buffer", 11'(exp_buf), 11'(serial_buffer));
		cmp("rx ninth", 11'(exp_nin), 11'(rx_ninth_bit_flag));
		cmp("rx done", 11'(clr ? take : 1'b1), 11'(rx_done_flag));
		$display("rx test mode %0d take %0d ended", md, take);
	endtask
	// Sends one byte, then receives one, in synchronous mode at the fast shift rate.
	task automatic t_m0(input logic [7:0] d, input logic [7:0] r);
		logic [7:0] got;
		int         t0;
		setup(2'h0, 1'b1, 1'b0);
		multiproc_select_bit = 1'b1;
		serial_buffer_wdata = d;
		serial_buffer_wr = 1'b1;
		@(posedge clock);
		#1 serial_buffer_wr = 1'b0;
		t0 = 0;
		for (int i = 0; i < 8; i++) begin
			@(posedge txd_pin);
			if (i == 0) begin
				t0 = int'($time);
			end
			got[i] = rxd_in;
		end
		cmp("m0 rate", 11'h01C, 11'((int'($time) - t0) / 4));
		repeat (4) @(posedge clock);
		cmp("m0 tx data", 11'(d), 11'(got));
		cmp("m0 tx done", 11'h001, 11'(tx_done_flag));
		#1 rx_done_clr = 1'b1;
		@(posedge clock);
		#1 rx_done_clr = 1'b0;
		u_rem.feed_sync(r);
		repeat (40) @(posedge clock);
		cmp("m0 rx buffer", 11'(r), 11'(serial_buffer));
		cmp("m0 rx done", 11'h001, 11'(rx_done_flag));
		$display("sync test ended");
	endtask
	// Main sequence.
	initial begin
		#1 rst_b = 1'b0;
		repeat (5) @(posedge clock);
		cmp("reset state", 11'h001, {serial_buffer, tx_done_flag, rx_done_flag, txd_pin});
		repeat (5) @(posedge clock);
		#1 rst_b = 1'b1;
		repeat (3) @(posedge clock);
		t_tx(2'h1, 1'b1, 8'hA5, 1'b0);
		t_tx(2'h2, 1'b1, 8'h3C, 1'b1);
		t_tx(2'h3, 1'b1, 8'h81, 1'b0);
		t_tx(2'h2, 1'b0, 8'h7E, 1'b1);
		t_rx(2'h2, 1'b1, 9'h1A5, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
		t_rx(2'h2, 1'b1, 9'h0F0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
		t_rx(2'h1, 1'b0, 9'h05A, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
		t_rx(2'h1, 1'b0, 9'h0C3, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
		t_rx(2'h3, 1'b1, 9'h066, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
		t_rx(2'h2, 1'b1, 9'h133, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		#1 rx_enable = 1'b1;
		u_rem.send(10'h000, 0, 1'b1, 8);
		t_rx(2'h2, 1'b1, 9'h0E1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
		t_m0(8'h4B, 8'hD2);
		complete_run();
	end
	// Cuts a hang short well beyond the expected run time.
	initial begin
		#200000 errors++;
		complete_run();
	end
endmodule // aspm_core_tb
